//--- core/ssc_standby_ctrl.sv
// standby controller: halt and stop entry, clock gating, bus hold and wake-up timing
// assumes the core pulses the instruction strobes for one cycle and stalls while cpu_clk_en_o is low
`timescale 1ns/10ps

module ssc_standby_ctrl #(
  parameter int unsigned NUM_IRQ = 8,
  parameter logic [17:0] STAB_C1 = 18'h04000,
  parameter logic [17:0] STAB_C2 = 18'h08000,
  parameter logic [17:0] STAB_C3 = 18'h10000,
  parameter logic [17:0] STAB_C4 = 18'h20000
) (
  input  wire logic                      sys_clk_i,
  input  wire logic                      srst_i,
  input  wire logic                      halt_exec_i,
  input  wire logic                      stop_exec_i,
  input  wire logic                      on_subclk_i,
  input  wire logic                      main_osc_stopped_i,
  input  wire logic                      ext_sclk_sel_i,
  input  wire ssc_pkg::ssc_irq_t [NUM_IRQ-1:0] irq_i,
  input  wire logic                      interrupt_enable_flag_i,
  input  wire logic                      in_service_priority_flag_i,
  input  wire logic                      nmi_src_i,
  input  wire logic                      stab_sel_wr_i,
  input  wire logic [2:0]                stab_sel_data_i,
  input  wire logic                      ext_exp_i,
  input  wire ssc_pkg::ssc_bus_t         core_bus_i,
  output ssc_pkg::ssc_bus_t              bus_o,
  output logic [2:0]                     stabilization_wait_select_o,
  output logic                           cpu_clk_en_o,
  output logic                           main_osc_en_o,
  output logic                           sub_osc_en_o,
  output logic                           crystal_output_pin_pullup_o,
  output logic                           serial_clk_en_o,
  output logic                           nmi_req_o,
  output logic                           standby_o,
  output logic                           resume_o,
  output logic                           vector_o
);

  ssc_pkg::ssc_state_t state_reg;
  ssc_pkg::ssc_state_t state_next;
  logic [17:0]         cnt_reg;
  logic [17:0]         cnt_next;
  logic                vector_reg;
  logic                vector_next;
  logic [2:0]          sel_reg;
  logic [2:0]          sel_next;
  ssc_pkg::ssc_bus_t   bus_reg;
  ssc_pkg::ssc_bus_t   bus_next;
  logic                release_req;
  logic                service_req;

  // decides release and servicing from the interrupt controller flags
  function automatic logic [1:0] wake_decide(input ssc_pkg::ssc_irq_t [NUM_IRQ-1:0] irq,
                                             input logic ack_en, input logic in_svc);
    logic lo_hit;
    logic hi_hit;
    lo_hit = 1'b0;
    hi_hit = 1'b0;
    for (int i = 0; i < NUM_IRQ; i++) begin
      if (irq[i].pending && !irq[i].interrupt_mask_flag) begin
        if (irq[i].interrupt_priority_flag)
          hi_hit = 1'b1;
        else
          lo_hit = 1'b1;
      end
    end
    wake_decide = {lo_hit | hi_hit, (lo_hit & ack_en) | (hi_hit & ack_en & in_svc)};
  endfunction

  // stabilization count minus one; code 0 is short enough to be a constant
  function automatic logic [17:0] stab_load(input logic [2:0] code);
    unique case (code)
      3'h0:    stab_load = 18'((1 << ssc_pkg::STAB_EXP0) - 1);
      3'h1:    stab_load = STAB_C1 - 18'h00001;
      3'h2:    stab_load = STAB_C2 - 18'h00001;
      3'h3:    stab_load = STAB_C3 - 18'h00001;
      default: stab_load = STAB_C4 - 18'h00001;
    endcase
  endfunction

  // nmi never raised while the core runs on the subsystem clock
  assign nmi_req_o = nmi_src_i & ~on_subclk_i;

  // release and servicing outcome of the flags as they stand this cycle
  always_comb begin
    {release_req, service_req} = wake_decide(irq_i, interrupt_enable_flag_i, in_service_priority_flag_i);
  end

  // standby sequencer next state
  always_comb begin
    state_next  = state_reg;
    cnt_next    = cnt_reg;
    vector_next = vector_reg;
    unique case (state_reg)
      ssc_pkg::SSC_RUN: begin
        if (stop_exec_i && !on_subclk_i) begin
          // a pending unmasked source would wake it at once, so skip stop
          state_next = release_req ? ssc_pkg::SSC_HALT : ssc_pkg::SSC_STOP;
        end else if (halt_exec_i) begin
          state_next = ssc_pkg::SSC_HALT;
        end
      end
      ssc_pkg::SSC_HALT: begin
        if (nmi_req_o) begin
          state_next  = ssc_pkg::SSC_WAKE;
          vector_next = 1'b1;
          cnt_next    = 18'(ssc_pkg::WAKE_VEC_CLKS - 1);
        end else if (release_req) begin
          state_next  = ssc_pkg::SSC_WAKE;
          vector_next = service_req;
          cnt_next    = service_req ? 18'(ssc_pkg::WAKE_VEC_CLKS - 1)
                                    : 18'(ssc_pkg::WAKE_NEXT_CLKS - 1);
        end
      end
      ssc_pkg::SSC_STOP: begin
        if (release_req) begin
          state_next = ssc_pkg::SSC_STAB;
          cnt_next   = stab_load(sel_reg);
        end
      end
      ssc_pkg::SSC_STAB: begin
        // servicing follows the flags through the wait, so vector_o is already valid with resume_o
        cnt_next    = cnt_reg - 18'h00001;
        vector_next = service_req;
        if (cnt_reg == 18'h00000)
          state_next = ssc_pkg::SSC_RUN;
      end
      ssc_pkg::SSC_WAKE: begin
        cnt_next = cnt_reg - 18'h00001;
        if (cnt_reg == 18'h00000)
          state_next = ssc_pkg::SSC_RUN;
      end
    endcase
  end

  // reset wins over every standby state and restarts the core
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      state_reg  <= ssc_pkg::SSC_RUN;
      cnt_reg    <= 18'h00000;
      vector_reg <= 1'b0;
    end else begin
      state_reg  <= state_next;
      cnt_reg    <= cnt_next;
      vector_reg <= vector_next;
    end
  end

  // stabilization select; prohibited codes are dropped so the field stays legal
  always_comb begin
    sel_next = sel_reg;
    if (stab_sel_wr_i && stab_sel_data_i <= ssc_pkg::SEL_MAX)
      sel_next = stab_sel_data_i;
  end

  // reset reloads the longest wait, the safe choice for an unknown crystal
  always_ff @(posedge sys_clk_i) begin
    if (srst_i)
      sel_reg <= ssc_pkg::SEL_RESET;
    else
      sel_reg <= sel_next;
  end

  // expansion bus: core drives it when running, standby parks it
  always_comb begin
    bus_next = core_bus_i;
    if (state_next != ssc_pkg::SSC_RUN && ext_exp_i) begin
      // ad data keeps following the core; nobody sees it while ad_oe_n is high
      bus_next.ad_oe_n             = 1'b1;
      bus_next.upper_address_lines = bus_reg.upper_address_lines;
      bus_next.address_strobe      = 1'b0;
      bus_next.rd_n                = 1'b1;
      bus_next.wr_n                = 1'b1;
      bus_next.wait_oe_n           = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i)
      bus_reg <= '{8'h00, 1'b1, 8'h00, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1};
    else
      bus_reg <= bus_next;
  end

  // clock and pin controls follow the registered state
  assign cpu_clk_en_o                = (state_reg == ssc_pkg::SSC_RUN);
  assign main_osc_en_o               = (state_reg != ssc_pkg::SSC_STOP);
  assign sub_osc_en_o                = 1'b1; // subsystem oscillator is never stopped
  assign crystal_output_pin_pullup_o = (state_reg == ssc_pkg::SSC_STOP);
  // serial logic has no clock of its own once both cpu and main clocks are gone
  assign serial_clk_en_o = ((state_reg == ssc_pkg::SSC_HALT && on_subclk_i && main_osc_stopped_i)
                            || state_reg == ssc_pkg::SSC_STOP) ? ext_sclk_sel_i : 1'b1;
  assign standby_o       = (state_reg != ssc_pkg::SSC_RUN);
  assign resume_o        = (state_reg == ssc_pkg::SSC_WAKE || state_reg == ssc_pkg::SSC_STAB)
                           && cnt_reg == 18'h00000;
  assign vector_o        = vector_reg;
  assign bus_o           = bus_reg;
  assign stabilization_wait_select_o = sel_reg;

  a_halt_clk_gate: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    state_reg == ssc_pkg::SSC_HALT |-> !cpu_clk_en_o && main_osc_en_o && sub_osc_en_o)
    else $error("halt left cpu clock running or an oscillator stopped");

  a_halt_entry: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    state_reg == ssc_pkg::SSC_RUN && halt_exec_i && !stop_exec_i |=> standby_o && !cpu_clk_en_o)
    else $error("halt instruction did not stop the cpu clock");

  a_serial_gate: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    state_reg == ssc_pkg::SSC_HALT && on_subclk_i && main_osc_stopped_i && !ext_sclk_sel_i
    |-> !serial_clk_en_o)
    else $error("serial clock enabled without external clock");

  a_bus_park: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    standby_o && ext_exp_i && $past(standby_o) |-> bus_o.ad_oe_n && !bus_o.address_strobe && bus_o.rd_n
    && bus_o.wr_n && bus_o.wait_oe_n && $stable(bus_o.upper_address_lines))
    else $error("expansion bus not parked during standby");

  a_wake_vec: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    state_reg == ssc_pkg::SSC_HALT && (nmi_req_o || (release_req && service_req))
    |-> !resume_o [*8] ##1 resume_o && vector_o)
    else $error("vectored halt release not after 8 clocks");

  a_wake_next: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    state_reg == ssc_pkg::SSC_HALT && !nmi_req_o && release_req && !service_req
    |-> ##2 resume_o && !vector_o ##1 cpu_clk_en_o)
    else $error("plain halt release not after 2 clocks");

  a_reset_run: assert property (@(posedge sys_clk_i)
    srst_i |=> cpu_clk_en_o && !standby_o && stabilization_wait_select_o == ssc_pkg::SEL_RESET)
    else $error("reset did not release standby");

  a_masked_hold: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    state_reg == ssc_pkg::SSC_HALT && !release_req && !nmi_req_o |=> state_reg == ssc_pkg::SSC_HALT)
    else $error("masked request released halt");

  a_stop_subclk: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    state_reg == ssc_pkg::SSC_RUN && stop_exec_i && on_subclk_i |=> !crystal_output_pin_pullup_o)
    else $error("stop entered on the subsystem clock");

  a_stop_pullup: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    state_reg == ssc_pkg::SSC_STOP |-> crystal_output_pin_pullup_o && !main_osc_en_o)
    else $error("crystal pin not pulled up in stop");

  a_stop_fallback: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    state_reg == ssc_pkg::SSC_RUN && stop_exec_i && !on_subclk_i && release_req
    |=> state_reg == ssc_pkg::SSC_HALT && main_osc_en_o)
    else $error("stop held despite a pending unmasked request");

  a_stab_wait: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    state_reg == ssc_pkg::SSC_STOP && release_req && sel_reg == 3'h0
    |=> !resume_o [*8] ##1 state_reg == ssc_pkg::SSC_STAB)
    else $error("stop released before stabilization");

  a_nmi_subclk: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    state_reg == ssc_pkg::SSC_HALT && on_subclk_i && !release_req |=> state_reg == ssc_pkg::SSC_HALT)
    else $error("nmi woke halt on the subsystem clock");

  a_nmi_gate: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    on_subclk_i |-> !nmi_req_o)
    else $error("nmi raised while on the subsystem clock");

  a_stop_entry: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    state_reg == ssc_pkg::SSC_RUN && stop_exec_i && !on_subclk_i && !release_req
    |=> state_reg == ssc_pkg::SSC_STOP && !cpu_clk_en_o)
    else $error("stop instruction did not enter stop");

  a_stop_hold: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    state_reg == ssc_pkg::SSC_STOP && !release_req |=> state_reg == ssc_pkg::SSC_STOP)
    else $error("stop left without an unmasked request");

  a_stab_osc_run: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    state_reg == ssc_pkg::SSC_STAB |-> main_osc_en_o && !crystal_output_pin_pullup_o && !cpu_clk_en_o)
    else $error("oscillator not running during the stabilization wait");

  a_sel_legal: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    stabilization_wait_select_o <= ssc_pkg::SEL_MAX)
    else $error("stabilization select holds a prohibited code");

  a_resume_run: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    resume_o |=> cpu_clk_en_o && !standby_o)
    else $error("core not running after resume");

  a_resume_pulse: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    resume_o |=> !resume_o)
    else $error("resume lasted more than one cycle");

endmodule

//--- shared/ssc_pkg.sv
// standby (halt / stop) controller constants, states and carrier types
// assumes one 100 MHz system clock that also serves as the main clock count base
package ssc_pkg;
  // wait after a halt release, in cpu clocks
  localparam int unsigned WAKE_VEC_CLKS  = 8;
  localparam int unsigned WAKE_NEXT_CLKS = 2;
  // stabilization wait select field
  localparam int unsigned   SEL_W     = 3;
  localparam logic [2:0]    SEL_RESET = 3'h4;
  localparam logic [2:0]    SEL_MAX   = 3'h4;
  // exponents of the main-clock periods for codes 0 to 4
  localparam int unsigned STAB_EXP0 = 12;
  localparam int unsigned STAB_EXP1 = 14;
  localparam int unsigned STAB_EXP2 = 15;
  localparam int unsigned STAB_EXP3 = 16;
  localparam int unsigned STAB_EXP4 = 17;
  localparam int unsigned CNT_W     = 18;

  typedef enum logic [2:0] {
    SSC_RUN,
    SSC_HALT,
    SSC_STOP,
    SSC_STAB,
    SSC_WAKE
  } ssc_state_t;

  // external expansion bus pins; oe_n low while the device drives
  typedef struct packed {
    logic [7:0] muxed_address_data_lines;
    logic       ad_oe_n;
    logic [7:0] upper_address_lines;
    logic       address_strobe;
    logic       rd_n;
    logic       wr_n;
    logic       wait_out;
    logic       wait_oe_n;
  } ssc_bus_t;

  // per-source interrupt view from the interrupt controller
  typedef struct packed {
    logic pending;
    logic interrupt_mask_flag;
    logic interrupt_priority_flag;
  } ssc_irq_t;
endpackage

//--- verification/ssc_core_model.sv
// behavioural core: drives the expansion bus while its clock runs
// assumes cpu_clk_en_i comes from the standby controller; the core freezes while it is low
`timescale 1ns/10ps

module ssc_core_model (
  input  wire logic        sys_clk_i,
  input  wire logic        srst_i,
  input  wire logic        cpu_clk_en_i,
  output ssc_pkg::ssc_bus_t core_bus_o
);
  ssc_pkg::ssc_bus_t bus_reg;
  ssc_pkg::ssc_bus_t bus_next;

  // a running core holds both oe_n low and changes every other pin each cycle, so a bus that is not parked shows it
  always_comb begin
    bus_next = bus_reg;
    if (cpu_clk_en_i) begin
      bus_next.upper_address_lines      = bus_reg.upper_address_lines + 8'h01;
      bus_next.muxed_address_data_lines = ~bus_reg.muxed_address_data_lines;
      bus_next.ad_oe_n                  = 1'b0;
      bus_next.address_strobe           = ~bus_reg.address_strobe;
      bus_next.rd_n                     = ~bus_reg.rd_n;
      bus_next.wr_n                     = bus_reg.rd_n;
      bus_next.wait_out                 = ~bus_reg.wait_out;
      bus_next.wait_oe_n                = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      bus_reg <= '0;
    end else begin
      bus_reg <= bus_next;
    end
  end

  assign core_bus_o = bus_reg;
endmodule

//--- verification/ssc_standby_ctrl_tb.sv
// bench for the standby controller: halt and stop entry, release outcomes and wait counts
// assumes short stabilization parameters; inputs change 1 ns after the rising edge
`timescale 1ns/10ps

module ssc_standby_ctrl_tb;
  logic                    sys_clk_i = 1'b0;
  logic                    srst_i = 1'b1;
  logic                    halt_i = 1'b0, stop_i = 1'b0, subclk_i = 1'b0, mstop_i = 1'b0, xsclk_i = 1'b0;
  logic                    ien_i = 1'b0, insvc_i = 1'b0, nmi_i = 1'b0, wr_i = 1'b0, exp_i = 1'b1;
  logic [2:0]              wdat_i = 3'h0;
  ssc_pkg::ssc_irq_t [7:0] irq_i = '0;
  ssc_pkg::ssc_bus_t       core_bus, bus_o, parked;
  logic [2:0]              sel_o;
  logic                    cpu_en, mosc, sosc, pull, sclk, nmi_req, stby, resume, vec;
  logic [5:0]              tbl [6] = '{6'h01, 6'h0E, 6'h15, 6'h19, 6'h1E, 6'h2C};
  int                      waits [5] = '{4096, 16, 32, 64, 128};
  int                      n_fail = 0;
  int                      cmp_count = 0;

  ssc_core_model CORE (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .cpu_clk_en_i(cpu_en), .core_bus_o(core_bus));

  ssc_standby_ctrl #(.STAB_C1(18'h00010), .STAB_C2(18'h00020), .STAB_C3(18'h00040), .STAB_C4(18'h00080)) DUT (
    .sys_clk_i(sys_clk_i), .srst_i(srst_i), .halt_exec_i(halt_i), .stop_exec_i(stop_i),
    .on_subclk_i(subclk_i), .main_osc_stopped_i(mstop_i), .ext_sclk_sel_i(xsclk_i), .irq_i(irq_i),
    .interrupt_enable_flag_i(ien_i), .in_service_priority_flag_i(insvc_i), .nmi_src_i(nmi_i),
    .stab_sel_wr_i(wr_i), .stab_sel_data_i(wdat_i), .ext_exp_i(exp_i), .core_bus_i(core_bus), .bus_o(bus_o),
    .stabilization_wait_select_o(sel_o), .cpu_clk_en_o(cpu_en), .main_osc_en_o(mosc), .sub_osc_en_o(sosc),
    .crystal_output_pin_pullup_o(pull), .serial_clk_en_o(sclk), .nmi_req_o(nmi_req), .standby_o(stby),
    .resume_o(resume), .vector_o(vec));

  // free-running 100 MHz clock
  initial begin
    forever #5 sys_clk_i = ~sys_clk_i;
  end

  task automatic cyc(input int k);
    repeat (k) @(posedge sys_clk_i);
    #1;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict;
    $display("comparisons=%0d mismatches=%0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic pulse(input bit stop);
    if (stop) stop_i = 1'b1;
    else halt_i = 1'b1;
    cyc(1);
    stop_i = 1'b0;
    halt_i = 1'b0;
  endtask

  // request already raised by the caller; a negative count skips the count check
  task automatic release_wait(input int exp_n, input logic exp_v);
    int n;
    n = 0;
    while (n < 5000 && resume !== 1'b1) begin
      cyc(1);
      n++;
    end
    if (n == 5000) begin
      n_fail++;
      print_verdict();
    end
    if (exp_n >= 0) chk(n, exp_n);
    chk(vec, exp_v);
    cyc(1);
    chk({cpu_en, stby}, 2'h2);
    irq_i = '0;
    nmi_i = 1'b0;
  endtask

  initial begin
    cyc(20);
    srst_i = 1'b0;
    chk({sel_o, sosc}, 4'h9);
    // halt on the subsystem clock with the main oscillator stopped and the bus expanded
    subclk_i = 1'b1;
    mstop_i = 1'b1;
    cyc(3);
    pulse(1'b0);
    chk({stby, cpu_en, mosc, sosc}, 4'hB);
    parked = bus_o;
    chk({parked.ad_oe_n, parked.address_strobe, parked.rd_n, parked.wr_n, parked.wait_oe_n}, 5'h17);
    chk(sclk, 1'b0);
    xsclk_i = 1'b1;
    cyc(5);
    chk(sclk, 1'b1);
    // the floated ad and wait lines carry no meaning, so only held and driven fields are compared
    chk({bus_o.upper_address_lines, bus_o.ad_oe_n, bus_o.address_strobe, bus_o.rd_n, bus_o.wr_n, bus_o.wait_oe_n},
        {parked.upper_address_lines, 5'h17});
    nmi_i = 1'b1;
    cyc(1);
    chk(nmi_req, 1'b0);
    chk(stby, 1'b1);
    nmi_i = 1'b0;
    subclk_i = 1'b0;
    mstop_i = 1'b0;
    irq_i[2].pending = 1'b1;
    release_wait(ssc_pkg::WAKE_NEXT_CLKS, 1'b0);
    // every line of the mask / priority / enable / in-service table; masked one ends by nmi
    for (int i = 0; i < 6; i++) begin
      pulse(1'b0);
      irq_i[5] = '{1'b1, tbl[i][5], tbl[i][4]};
      ien_i = tbl[i][3];
      insvc_i = tbl[i][2];
      if (tbl[i][1:0] == 2'h0) begin
        cyc(12);
        chk({stby, cpu_en}, 2'h2);
        ien_i = 1'b0;
        nmi_i = 1'b1;
        release_wait(ssc_pkg::WAKE_VEC_CLKS, 1'b1);
      end else begin
        release_wait(tbl[i][1] ? ssc_pkg::WAKE_VEC_CLKS : ssc_pkg::WAKE_NEXT_CLKS, tbl[i][1]);
      end
    end
    // prohibited select code is dropped
    wdat_i = 3'h5;
    wr_i = 1'b1;
    cyc(1);
    wr_i = 1'b0;
    cyc(1);
    chk(sel_o, 3'h4);
    // stop is refused on the subsystem clock
    subclk_i = 1'b1;
    pulse(1'b1);
    cyc(2);
    chk(stby, 1'b0);
    subclk_i = 1'b0;
    // each select code, stop held against nmi, released by an unmasked request
    for (int c = 0; c < 5; c++) begin
      wdat_i = c[2:0];
      wr_i = 1'b1;
      cyc(1);
      wr_i = 1'b0;
      ien_i = c[0];
      pulse(1'b1);
      chk({stby, mosc, pull}, 3'h5);
      nmi_i = 1'b1;
      cyc(3);
      chk({stby, mosc}, 2'h2);
      nmi_i = 1'b0;
      irq_i[0].pending = 1'b1;
      release_wait(waits[c], c[0]);
    end
    // pending unmasked request turns stop into halt
    irq_i[1].pending = 1'b1;
    pulse(1'b1);
    chk({stby, mosc, pull}, 3'h6);
    // enable flag is still low from the last select code, so this is a plain release
    release_wait(ssc_pkg::WAKE_NEXT_CLKS, 1'b0);
    // reset leaves halt and stop at once
    for (int s = 0; s < 2; s++) begin
      // a code other than the reset one, so the reload is visible
      wdat_i = 3'h1;
      wr_i = 1'b1;
      cyc(1);
      wr_i = 1'b0;
      pulse(s[0]);
      srst_i = 1'b1;
      cyc(1);
      srst_i = 1'b0;
      chk({cpu_en, stby, mosc, sel_o}, 6'h2C);
    end
    print_verdict();
  end
endmodule
